// file: design/hbofc_pkg.sv
package hbofc_pkg;
  localparam int NCH = 10;
  localparam int GRP_SLOTS = 6;
  localparam int GRP_B_BASE = 6;
  localparam logic [9:0] GRP_A_MASK = 10'h03F;
  localparam logic [9:0] GRP_B_MASK = 10'h3C0;
  // timebase
  localparam int CLK_NS = 4;
  localparam int NOV_NS = 500;
  localparam int SRR_NS = 100000;
  localparam int NOV_CYC = (NOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int SRR_CYC = (SRR_NS + CLK_NS - 1) / CLK_NS;
  // command word fields
  localparam int C_OVERVOLTAGE_LOCKOUT_ENABLE = 0;
  localparam int C_SIDE = 1;
  localparam int C_EN = 7;
  localparam int C_UNDERLOAD_SHUTDOWN_ENABLE = 13;
  localparam int C_SEL = 14;
  localparam int C_SRR = 15;
  // status word fields
  localparam int S_TW = 0;
  localparam int S_HBST = 1;
  localparam int S_ULD = 13;
  localparam int S_PSF = 14;
  localparam int S_OCS = 15;
  localparam logic [1:0] HB_OFF = 2'h0;
  localparam logic [1:0] HB_OCS = 2'h1;
  localparam logic [1:0] HB_ULD = 2'h2;
  localparam logic [1:0] HB_ON = 2'h3;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [4:0] FRM_LEN = 5'h10;
  // synchroniser bit positions
  localparam int A_SCLK = 0;
  localparam int A_SI = 1;
  localparam int A_CSN = 2;
  localparam int A_EN = 3;
  localparam int A_UV = 4;
  localparam int A_OV = 5;
  localparam int A_VUV = 6;
  localparam int A_PLS = 7;
  localparam int A_TW = 9;
  localparam int A_TSD = 19;
  localparam int A_OC = 29;
  localparam int A_UL = 39;
  localparam int A_W = 49;
endpackage

// file: design/hbofc_top.sv
`timescale 1ns/1ps
module hbofc_top #(
  parameter int NOV_CYCLES = hbofc_pkg::NOV_CYC,
  parameter int SRR_HOLD_CYCLES = hbofc_pkg::SRR_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic spi_sclk,
  input wire logic spi_si,
  input wire logic chip_select_n,
  input wire logic enable_pin,
  input wire logic driver_supply_undervoltage,
  input wire logic driver_supply_overvoltage,
  input wire logic logic_supply_undervoltage,
  input wire logic ext_pulse_in_1,
  input wire logic ext_pulse_in_2,
  input wire logic [9:0] thermal_warn_in,
  input wire logic [9:0] thermal_sd_in,
  input wire logic [9:0] overcurrent_in,
  input wire logic [9:0] underload_in,
  output logic spi_so,
  output logic spi_so_oe_n,
  output logic [9:0] hs_drive,
  output logic [9:0] ls_drive
);
  localparam int NW = $clog2(NOV_CYCLES + 1);
  localparam int HW = $clog2(SRR_HOLD_CYCLES + 1);

  if (NOV_CYCLES < 1 || SRR_HOLD_CYCLES < 1) begin : g_chk
    $error("cycle counts must be at least one");
  end

  typedef struct packed {
    logic [hbofc_pkg::A_W-1:0] am;
    logic [hbofc_pkg::A_W-1:0] as;
    logic sclk_d;
    logic cs_d;
    logic en_d;
    logic [9:0] side;
    logic [9:0] ena;
    logic overvoltage_lockout_enable;
    logic underload_shutdown_enable;
    logic sel;
    logic [15:0] isr;
    logic [15:0] osr;
    logic [15:0] snap;
    logic tsd_snap;
    logic so;
    logic so_oe_n;
    logic [2:0] b8;
    logic [4:0] b16;
    logic [9:0] ocs_l;
    logic [9:0] uld_l;
    logic [9:0] tsd_l;
    logic [9:0] hs;
    logic [9:0] ls;
    logic [9:0][NW-1:0] dead;
    logic [HW-1:0] hold;
  } hbofc_state_s;

  hbofc_state_s q;
  hbofc_state_s d;
  logic [hbofc_pkg::A_W-1:0] ain;
  logic sclk, si, csn, en_p, uv, ov, vuv;
  logic [1:0] pls;
  logic [9:0] tw, tsd, oc, ul;
  logic lock, cs_fall, cs_rise, rise, en_fall, frm_ok;
  logic [9:0] clr, shut, on_req, want_h, want_l, flt;
  logic [15:0] sw;
  int ch;

  // async inputs pass two flip-flops (am, as) before use
  assign ain = {underload_in, overcurrent_in, thermal_sd_in,
    thermal_warn_in, ext_pulse_in_2, ext_pulse_in_1,
    logic_supply_undervoltage, driver_supply_overvoltage,
    driver_supply_undervoltage, enable_pin, chip_select_n,
    spi_si, spi_sclk};
  assign sclk = q.as[hbofc_pkg::A_SCLK];
  assign si = q.as[hbofc_pkg::A_SI];
  assign csn = q.as[hbofc_pkg::A_CSN];
  assign en_p = q.as[hbofc_pkg::A_EN];
  assign uv = q.as[hbofc_pkg::A_UV];
  assign ov = q.as[hbofc_pkg::A_OV];
  assign vuv = q.as[hbofc_pkg::A_VUV];
  assign pls = q.as[hbofc_pkg::A_PLS +: 2];
  assign tw = q.as[hbofc_pkg::A_TW +: 10];
  assign tsd = q.as[hbofc_pkg::A_TSD +: 10];
  assign oc = q.as[hbofc_pkg::A_OC +: 10];
  assign ul = q.as[hbofc_pkg::A_UL +: 10];
  assign flt = q.ocs_l | q.tsd_l;

  assign spi_so = q.so;
  assign spi_so_oe_n = q.so_oe_n;
  assign hs_drive = q.hs;
  assign ls_drive = q.ls;

  always_comb begin
    d = q;
    ch = 0;
    sw = hbofc_pkg::WORD_RST;
    clr = '0;
    d.am = ain;
    d.as = q.am;
    d.sclk_d = sclk;
    d.cs_d = csn;
    d.en_d = en_p;
    lock = uv | (ov & q.overvoltage_lockout_enable);
    cs_fall = q.cs_d & ~csn;
    cs_rise = ~q.cs_d & csn;
    rise = sclk & ~q.sclk_d & ~csn;
    en_fall = q.en_d & ~en_p;
    frm_ok = (q.b16 == hbofc_pkg::FRM_LEN) && (q.b8 == 3'h0);
    // serial frame
    if (cs_fall) begin
      d.osr = q.snap;
      d.so = q.tsd_snap | si;
      d.so_oe_n = 1'b0;
      d.b8 = 3'h0;
      d.b16 = 5'h00;
    end else if (rise) begin
      d.so = q.osr[15];
      d.osr = {q.osr[14:0], si};
      d.isr = {q.isr[14:0], si};
      d.b8 = q.b8 + 3'h1;
      if (q.b16 != hbofc_pkg::FRM_LEN) begin
        d.b16 = q.b16 + 5'h01;
      end
    end
    if (q.hold != '0) begin
      d.hold = q.hold - HW'(1);
    end
    if (cs_rise) begin
      d.so_oe_n = 1'b1;
      if (frm_ok) begin
        d.overvoltage_lockout_enable = q.isr[hbofc_pkg::C_OVERVOLTAGE_LOCKOUT_ENABLE];
        d.underload_shutdown_enable = q.isr[hbofc_pkg::C_UNDERLOAD_SHUTDOWN_ENABLE];
        d.sel = q.isr[hbofc_pkg::C_SEL];
        for (int k = 0; k < hbofc_pkg::GRP_SLOTS; k++) begin
          ch = q.isr[hbofc_pkg::C_SEL] ? hbofc_pkg::GRP_B_BASE + k : k;
          if (ch < hbofc_pkg::NCH) begin
            d.side[ch] = q.isr[hbofc_pkg::C_SIDE + k];
            d.ena[ch] = q.isr[hbofc_pkg::C_EN + k];
          end
        end
        if (q.isr[hbofc_pkg::C_SRR]) begin
          clr = q.isr[hbofc_pkg::C_SEL] ? hbofc_pkg::GRP_B_MASK
                                        : hbofc_pkg::GRP_A_MASK;
          d.hold = HW'(SRR_HOLD_CYCLES);
        end
      end
    end
    if (en_fall) begin
      clr = '1;
    end
    if (vuv) begin
      clr = '1;
      d.side = '0;
      d.ena = '0;
      d.overvoltage_lockout_enable = 1'b0;
      d.underload_shutdown_enable = 1'b0;
      d.sel = 1'b0;
    end
    // latched faults, a new event wins over a clear except during logic undervoltage, which masks events
    d.ocs_l = (q.ocs_l & ~clr) | (oc & {10{~vuv}});
    d.tsd_l = (q.tsd_l & ~clr) | (tsd & {10{~vuv}});
    d.uld_l = (q.uld_l & ~clr)
            | (ul & (q.hs | q.ls) & {10{~vuv}});
    shut = q.ocs_l | q.tsd_l | (q.uld_l & {10{q.underload_shutdown_enable}});
    on_req = q.ena;
    on_req[0] = q.ena[0] | pls[0];
    on_req[1] = q.ena[1] | pls[1];
    on_req = on_req & ~shut & {10{~lock & en_p & ~vuv}};
    want_h = on_req & q.side;
    want_l = on_req & ~q.side;
    for (int i = 0; i < hbofc_pkg::NCH; i++) begin
      if ((q.hs[i] & ~want_h[i]) | (q.ls[i] & ~want_l[i])) begin
        d.hs[i] = 1'b0;
        d.ls[i] = 1'b0;
        d.dead[i] = NW'(NOV_CYCLES);
      end else if (~q.hs[i] & ~q.ls[i]) begin
        if (q.dead[i] != '0) begin
          d.dead[i] = q.dead[i] - NW'(1);
        end else begin
          d.hs[i] = want_h[i];
          d.ls[i] = want_l[i];
        end
      end
    end
    // status word of the selected group
    for (int k = 0; k < hbofc_pkg::GRP_SLOTS; k++) begin
      ch = q.sel ? hbofc_pkg::GRP_B_BASE + k : k;
      if (ch < hbofc_pkg::NCH) begin
        if (q.ocs_l[ch]) begin
          sw[hbofc_pkg::S_HBST + 2 * k +: 2] = hbofc_pkg::HB_OCS;
        end else if (q.uld_l[ch]) begin
          sw[hbofc_pkg::S_HBST + 2 * k +: 2] = hbofc_pkg::HB_ULD;
        end else if (q.hs[ch] | q.ls[ch]) begin
          sw[hbofc_pkg::S_HBST + 2 * k +: 2] = hbofc_pkg::HB_ON;
        end
      end
    end
    sw[hbofc_pkg::S_OCS] = |(q.ocs_l & (q.sel ? hbofc_pkg::GRP_B_MASK
                                              : hbofc_pkg::GRP_A_MASK));
    sw[hbofc_pkg::S_ULD] = |(q.uld_l & (q.sel ? hbofc_pkg::GRP_B_MASK
                                              : hbofc_pkg::GRP_A_MASK));
    sw[hbofc_pkg::S_PSF] = uv | ov;
    sw[hbofc_pkg::S_TW] = |tw;
    if (csn && !cs_rise && q.hold == '0) begin
      d.snap = sw;
      d.tsd_snap = |q.tsd_l;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.so_oe_n <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n || !clk_en);

  property p_no_overlap;
    (q.hs & q.ls) == '0;
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("high and low driver on together");

  property p_lock_off;
    lock |=> (q.hs | q.ls) == '0;
  endproperty
  a_lock_off: assert property (p_lock_off)
    else $error("driver on during supply lockout");

  property p_side;
    1'b1 |=> ((q.hs & ~$past(q.side)) | (q.ls & $past(q.side))) == '0;
  endproperty
  a_side: assert property (p_side)
    else $error("driver does not match side select");

  property p_fault_off;
    1'b1 |=> ((q.hs | q.ls) & $past(flt)) == '0;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("faulted channel still driven");

  property p_psf_clear;
    (csn && !cs_rise && q.hold == '0 && !uv && !ov)
      |=> !q.snap[hbofc_pkg::S_PSF];
  endproperty
  a_psf_clear: assert property (p_psf_clear)
    else $error("supply fail status did not self clear");

  property p_frozen;
    (!csn && !q.cs_d) |=> $stable(q.snap);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("status changed inside a frame");

  property p_hold;
    (cs_rise && frm_ok && q.isr[hbofc_pkg::C_SRR])
      |=> q.hold == HW'(SRR_HOLD_CYCLES) ##1 q.hold != '0;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold-off timer not started");

  property p_vcc_clear;
    vuv |=> (q.ena == '0 && q.side == '0 && flt == '0 && q.uld_l == '0);
  endproperty
  a_vcc_clear: assert property (p_vcc_clear)
    else $error("logic undervoltage did not clear words");

  property p_bad_frame;
    (cs_rise && !frm_ok && !vuv) |=> $stable(q.ena) && $stable(q.side);
  endproperty
  a_bad_frame: assert property (p_bad_frame)
    else $error("invalid frame changed command");
endmodule

// file: verif/hbofc_spi_host.sv
`timescale 1ns/1ps
module hbofc_spi_host (
  output logic sclk,
  output logic si,
  output logic cs_n,
  input wire logic so
);
  logic pre_bit;
  initial begin
    sclk = 1'b0;
    si = 1'b0;
    cs_n = 1'b1;
    pre_bit = 1'b0;
  end
  // frame of nbits, msb first; the last sixteen carry cmd
  task automatic xfer(input logic [15:0] cmd, input int nbits,
    output logic [15:0] sta);
    sta = 16'h0000;
    // quarter offset keeps pin changes off the sys_clk edges when xfer starts on a whole ns; right after another xfer they can land on edges
    #100.25 cs_n = 1'b0;
    // bit shown before the first sclk rise
    #50 pre_bit = so;
    for (int i = nbits - 1; i >= 0; i--) begin
      #62.5 si = cmd[i % 16];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
      sta = {sta[14:0], so};
    end
    #62.5 cs_n = 1'b1;
    si = 1'b0;
    #400;
  endtask
endmodule

// file: verif/hbofc_test.sv
`timescale 1ns/1ps
module hbofc_test;
  logic sys_clk, rst_n, en, dsuv, dsov, lsuv, p1, p2;
  logic [9:0] tw, tsd, oc, ul, hs, ls;
  logic sclk, si, cs_n, so, so_oe_n;
  logic [15:0] sta;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  hbofc_top #(.NOV_CYCLES(2), .SRR_HOLD_CYCLES(8)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .spi_sclk(sclk),
    .spi_si(si), .chip_select_n(cs_n), .enable_pin(en),
    .driver_supply_undervoltage(dsuv), .driver_supply_overvoltage(dsov),
    .logic_supply_undervoltage(lsuv), .ext_pulse_in_1(p1),
    .ext_pulse_in_2(p2), .thermal_warn_in(tw), .thermal_sd_in(tsd),
    .overcurrent_in(oc), .underload_in(ul), .spi_so(so),
    .spi_so_oe_n(so_oe_n), .hs_drive(hs), .ls_drive(ls));
  hbofc_spi_host host (.sclk(sclk), .si(si), .cs_n(cs_n), .so(so));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [9:0] h, input logic [9:0] l);
    @(negedge sys_clk);
    chk({6'h00, hs}, {6'h00, h});
    chk({6'h00, ls}, {6'h00, l});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  always @(negedge sys_clk) begin
    cyc++;
    if (rst_n === 1'b1) chk({6'h00, hs & ls}, 16'h0000);
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic t_reset();
    chk_out(10'h000, 10'h000);
    chk({15'h0000, so_oe_n}, 16'h0001);
    host.xfer(16'h0000, 16, sta);
    chk(sta, 16'h0000);
  endtask
  task automatic t_drive();
    host.xfer(16'h0182, 16, sta);
    chk_out(10'h001, 10'h002);
    host.xfer(16'h0182, 16, sta);
    chk(sta, 16'h001E);
    chk_out(10'h001, 10'h002);
  endtask
  task automatic t_ocs();
    @(posedge sys_clk) oc <= 10'h001;
    wt(10);
    oc <= 10'h000;
    wt(10);
    chk_out(10'h000, 10'h002);
    host.xfer(16'h0182, 16, sta);
    chk(sta, 16'h801A);
    host.xfer(16'h8182, 16, sta);
    chk_out(10'h001, 10'h002);
    host.xfer(16'h0182, 16, sta);
    chk(sta, 16'h001E);
    @(posedge sys_clk) oc <= 10'h001;
    wt(10);
    host.xfer(16'h8182, 16, sta);
    chk_out(10'h000, 10'h002);
    @(posedge sys_clk) oc <= 10'h000;
    host.xfer(16'h8182, 16, sta);
    chk_out(10'h001, 10'h002);
  endtask
  task automatic t_uld();
    @(posedge sys_clk) ul <= 10'h002;
    wt(10);
    ul <= 10'h000;
    chk_out(10'h001, 10'h002);
    host.xfer(16'h0182, 16, sta);
    chk(sta, 16'h2016);
    host.xfer(16'h8182, 16, sta);
  endtask
  task automatic t_supply();
    @(posedge sys_clk) dsuv <= 1'b1;
    wt(10);
    chk_out(10'h000, 10'h000);
    host.xfer(16'h0100, 16, sta);
    chk({15'h0000, sta[14]}, 16'h0001);
    @(posedge sys_clk) dsuv <= 1'b0;
    wt(10);
    chk_out(10'h000, 10'h002);
    host.xfer(16'h0100, 16, sta);
    chk(sta, 16'h0018);
    @(posedge sys_clk) dsov <= 1'b1;
    wt(10);
    chk_out(10'h000, 10'h002);
    host.xfer(16'h0101, 16, sta);
    chk({15'h0000, sta[14]}, 16'h0001);
    chk_out(10'h000, 10'h000);
    @(posedge sys_clk) dsov <= 1'b0;
    wt(10);
    chk_out(10'h000, 10'h002);
  endtask
  task automatic t_frame();
    host.xfer(16'h0000, 12, sta);
    chk_out(10'h000, 10'h002);
    host.xfer(16'h0182, 24, sta);
    chk_out(10'h001, 10'h002);
  endtask
  task automatic t_enable();
    @(posedge sys_clk) oc <= 10'h002;
    wt(10);
    oc <= 10'h000;
    en <= 1'b0;
    wt(10);
    chk_out(10'h000, 10'h000);
    @(posedge sys_clk) en <= 1'b1;
    wt(10);
    host.xfer(16'h0182, 16, sta);
    chk(sta, 16'h001E);
  endtask
  task automatic t_group();
    host.xfer(16'h4082, 16, sta);
    chk_out(10'h041, 10'h002);
    host.xfer(16'h4082, 16, sta);
    chk(sta, 16'h0006);
    host.xfer(16'h4000, 16, sta);
    chk_out(10'h001, 10'h002);
  endtask
  task automatic t_thermal();
    host.xfer(16'h0182, 16, sta);
    @(posedge sys_clk) tw <= 10'h004;
    tsd <= 10'h001;
    wt(10);
    tsd <= 10'h000;
    chk_out(10'h000, 10'h002);
    host.xfer(16'h0182, 16, sta);
    chk(sta, 16'h0019);
    chk({15'h0000, host.pre_bit}, 16'h0001);
    @(posedge sys_clk) tw <= 10'h000;
    host.xfer(16'h8182, 16, sta);
    chk_out(10'h001, 10'h002);
    host.xfer(16'h0182, 16, sta);
    chk(sta, 16'h001E);
    chk({15'h0000, host.pre_bit}, 16'h0000);
  endtask
  task automatic t_pulse();
    host.xfer(16'h0002, 16, sta);
    chk_out(10'h000, 10'h000);
    @(posedge sys_clk) p1 <= 1'b1;
    wt(10);
    chk_out(10'h001, 10'h000);
    @(posedge sys_clk) p1 <= 1'b0;
    p2 <= 1'b1;
    wt(10);
    chk_out(10'h000, 10'h002);
    p2 <= 1'b0;
    wt(10);
    chk_out(10'h000, 10'h000);
  endtask
  task automatic t_vcc();
    host.xfer(16'h0182, 16, sta);
    @(posedge sys_clk) lsuv <= 1'b1;
    wt(10);
    chk_out(10'h000, 10'h000);
    @(posedge sys_clk) lsuv <= 1'b0;
    wt(10);
    chk_out(10'h000, 10'h000);
    host.xfer(16'h0000, 16, sta);
    chk(sta, 16'h0000);
  endtask
  initial begin
    {rst_n, dsuv, dsov, lsuv, p1, p2} = 6'h00;
    en = 1'b1;
    {tw, tsd, oc, ul} = 40'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_drive();
    t_ocs();
    t_uld();
    t_supply();
    t_frame();
    t_enable();
    t_group();
    t_thermal();
    t_pulse();
    t_vcc();
    end_of_test();
  end
endmodule
